// File: pmbus_onoff_protect.v
// Contract
// - Switch-config write with broadcast page reaches every channel enabled in the mask.
// - No channel starts sequencing until input voltage exceeds the start threshold.
// - Controlled-on bit clear: channel powers up with sequencing regardless of pin or command.
// - Controlled-on bit set: power up only on pin and/or command; both selects clear means never.
// - Use-bus bit chooses whether the run command field is obeyed.
// - Use-pin bit chooses whether the run pin must be asserted to start.
// - Config bits 7..5 ignore writes, read zero; bit 1 reads one.
// - Pin turn-off waits the off delay, or with fast-off drops the enable at once.
// - Fault clear clears unpaged and current-page status and releases the alert line if no other page holds a set status bit.
// - Fault clear never restarts a channel latched off by a fault.
// - A still-present fault sets its status bit again and pulls the alert line.
// - Fault clear is not broadcast when the broadcast page is selected.
// - Reads of every supported command are allowed whatever the write lock.
// - Lock level one, level two and zero gate writes; other lock values are reserved.
// - Writes are refused while a store or restore is in progress.
// - Stored settings reload on restore command and after leaving reset.
// - Monitoring is suspended during store or restore transfers.
// - Feature byte reads bits 7..5 as one and bits 4..0 as zero.
// - Output voltage format reads linear mode 000b with exponent 0x13.
// - Ten output voltage registers per channel hold 16-bit fixed-exponent values.
// - Odd channels measuring current refuse their over/under voltage limit registers.
// - Page register selects channel 0..7 for every paged command and fault clear.
`timescale 1ns/1ps
`include "pmbus_onoff_defines.vh"

module pmbus_onoff_protect #(
  parameter CHANNELS   = 8,
  parameter CNT_W      = 16,
  parameter TON_DELAY  = 16'h0064,
  parameter TOFF_DELAY = 16'h0064
) (
  // Clock and reset
  input  wire                core_clk,
  input  wire                sys_rst,
  // Decoded command port from the serial-bus transaction layer
  input  wire                cmdValid,
  input  wire                cmdWrite,
  input  wire [7:0]          cmdCode,
  input  wire [15:0]         cmdWdata,
  output reg                 cmdDone,
  output reg                 cmdNack,
  output reg  [15:0]         cmdRdata,
  // Channel pins and comparators
  input  wire [CHANNELS-1:0] runRequestPin,
  input  wire                inputSenseAboveOn,
  input  wire [CHANNELS-1:0] channelFault,
  input  wire [3:0]          oddCurrentMode,
  output reg  [CHANNELS-1:0] converterEnableOutput,
  // Alert line, open drain
  output wire                hostAlertLineNOut,
  output reg                 hostAlertLineNOe,
  // User EEPROM transfer engine
  output reg                 eeStoreReq,
  output reg                 eeLoadReq,
  input  wire                eeDone,
  output reg                 monitorSuspend
);

  // Pin synchronisers
  reg  [CHANNELS-1:0] pinMeta_r;
  reg  [CHANNELS-1:0] pinSync_r;
  reg  [CHANNELS-1:0] faultMeta_r;
  reg  [CHANNELS-1:0] faultSync_r;
  reg                 vinMeta_r;
  reg                 vinSync_r;

  always @(posedge core_clk) begin
    if (sys_rst) begin
      pinMeta_r   <= {CHANNELS{1'b0}};
      pinSync_r   <= {CHANNELS{1'b0}};
      faultMeta_r <= {CHANNELS{1'b0}};
      faultSync_r <= {CHANNELS{1'b0}};
      vinMeta_r   <= 1'b0;
      vinSync_r   <= 1'b0;
    end else begin
      pinMeta_r   <= runRequestPin;
      pinSync_r   <= pinMeta_r;
      faultMeta_r <= channelFault;
      faultSync_r <= faultMeta_r;
      vinMeta_r   <= inputSenseAboveOn;
      vinSync_r   <= vinMeta_r;
    end
  end

  // Register state
  reg  [7:0]          page_r;
  reg  [7:0]          lock_r;
  reg  [7:0]          bcastMask_r;
  reg  [3:0]          cfg_r [0:CHANNELS-1];
  reg  [CHANNELS-1:0] runCmd_r;
  reg  [15:0]         vreg_r [0:CHANNELS*10-1];
  reg  [CHANNELS-1:0] faultStat_r;
  reg                 cml_r;
  reg  [CHANNELS-1:0] latched_r;
  reg  [1:0]          chState_r [0:CHANNELS-1];
  reg  [CNT_W-1:0]    chCnt_r [0:CHANNELS-1];
  reg                 busy_r;
  reg                 initDone_r;
  reg                 bootLoad_r;

  // Command decode
  wire [2:0] chan      = page_r[2:0];
  wire       pageOk    = (page_r <= `PAGE_LAST);
  wire       pageBcast = (page_r == `PAGE_BROADCAST);
  reg  [3:0] vsel;
  reg        isVreg;
  reg        isLimit;
  reg        known;
  reg        readOnly;
  reg        bcastOk;
  reg        paged;
  reg        lockOk;
  reg        nackNxt;
  reg [15:0] rdNxt;
  // Flat index into the limit array
  wire [6:0] vidx = {4'h0, chan} * `VREGS_PER_PAGE + {3'h0, vsel};
  // Odd current-mode pages lack limits
  wire       limitOff = chan[0] & oddCurrentMode[chan[2:1]];

  always @* begin
    vsel     = `VSEL_SETPOINT;
    isVreg   = 1'b1;
    isLimit  = 1'b0;
    known    = 1'b1;
    readOnly = 1'b0;
    bcastOk  = 1'b0;
    paged    = 1'b1;
    case (cmdCode)
      `CMD_VOUT_SETPOINT:  vsel = `VSEL_SETPOINT;
      `CMD_VOUT_CEILING:   vsel = `VSEL_CEILING;
      `CMD_MARGIN_UPPER:   vsel = `VSEL_MARGIN_UP;
      `CMD_MARGIN_LOWER:   vsel = `VSEL_MARGIN_LO;
      `CMD_OV_FAULT:       begin vsel = `VSEL_OV_FAULT; isLimit = 1'b1; end
      `CMD_OV_WARN:        begin vsel = `VSEL_OV_WARN;  isLimit = 1'b1; end
      `CMD_UV_WARN:        begin vsel = `VSEL_UV_WARN;  isLimit = 1'b1; end
      `CMD_UV_FAULT:       begin vsel = `VSEL_UV_FAULT; isLimit = 1'b1; end
      `CMD_GOOD_ASSERT:    vsel = `VSEL_GOOD_ON;
      `CMD_GOOD_DEASSERT:  vsel = `VSEL_GOOD_OFF;
      default:             isVreg = 1'b0;
    endcase
    case (cmdCode)
      `CMD_RUN, `CMD_SWITCH_CFG:              bcastOk = 1'b1;
      `CMD_STATUS_OUTPUT, `CMD_CLEAR_FAULTS:  ;
      `CMD_PAGE, `CMD_WRITE_LOCK, `CMD_STORE_ALL, `CMD_RESTORE_ALL, `CMD_BCAST_MASK,
      `CMD_STATUS_SUMMARY:                    paged = 1'b0;
      `CMD_FEATURES, `CMD_VOUT_FORMAT:        begin paged = 1'b0; readOnly = 1'b1; end
      default:                                known = isVreg;
    endcase
    if (cmdCode == `CMD_STATUS_SUMMARY || cmdCode == `CMD_STATUS_OUTPUT)
      readOnly = 1'b1;
    // Write lock levels
    case (lock_r)
      `LOCK_NONE:   lockOk = 1'b1;
      `LOCK_LEVEL1: lockOk = (cmdCode == `CMD_WRITE_LOCK) || (cmdCode == `CMD_PAGE) ||
                             (cmdCode == `CMD_STORE_ALL);
      `LOCK_LEVEL2: lockOk = (cmdCode == `CMD_WRITE_LOCK) || (cmdCode == `CMD_PAGE) ||
                             (cmdCode == `CMD_STORE_ALL) || (cmdCode == `CMD_RUN) ||
                             (cmdCode == `CMD_BCAST_MASK) || (cmdCode == `CMD_CLEAR_FAULTS);
      default:      lockOk = 1'b0;
    endcase
    nackNxt = !known;
    if (paged && !pageOk && !(bcastOk && pageBcast && cmdWrite))
      nackNxt = 1'b1;
    if (isLimit && limitOff)
      nackNxt = 1'b1;
    if (cmdWrite) begin
      if (busy_r || !lockOk || readOnly)
        nackNxt = 1'b1;
      // Reserved page values refused
      if (cmdCode == `CMD_PAGE && !(cmdWdata[7:0] <= `PAGE_LAST || cmdWdata[7:0] == `PAGE_BROADCAST))
        nackNxt = 1'b1;
      if (cmdCode == `CMD_WRITE_LOCK && !(cmdWdata[7:0] == `LOCK_NONE ||
          cmdWdata[7:0] == `LOCK_LEVEL1 || cmdWdata[7:0] == `LOCK_LEVEL2))
        nackNxt = 1'b1;
    end
    // Reads never consult the lock
    rdNxt = 16'h0000;
    case (cmdCode)
      `CMD_PAGE:           rdNxt = {8'h00, page_r};
      `CMD_RUN:            rdNxt = {8'h00, runCmd_r[chan], 7'h00};
      `CMD_SWITCH_CFG:     rdNxt = {11'h000, cfg_r[chan][`CFG_CONTROLLED_ON:`CFG_USE_PIN], 1'b0,
                                    cfg_r[chan][`CFG_FAST_OFF]} | {8'h00, `CFG_RD_ONE_BIT};
      `CMD_WRITE_LOCK:     rdNxt = {8'h00, lock_r};
      `CMD_BCAST_MASK:     rdNxt = {8'h00, bcastMask_r};
      `CMD_FEATURES:       rdNxt = {8'h00, `FEATURES_VALUE};
      `CMD_VOUT_FORMAT:    rdNxt = {8'h00, `VOUT_FORMAT_VALUE};
      `CMD_STATUS_SUMMARY: rdNxt = {8'h00, 6'h00, cml_r, 1'b0} << (`STATUS_CML_BIT - 1);
      `CMD_STATUS_OUTPUT:  rdNxt = {8'h00, faultStat_r[chan], 7'h00};
      default:             rdNxt = isVreg ? vreg_r[vidx] : 16'h0000;
    endcase
  end

  // Answered on the next edge
  wire take   = cmdValid;
  wire doWr   = take && cmdWrite && !nackNxt;
  wire clrHit = doWr && (cmdCode == `CMD_CLEAR_FAULTS);

  // Channel start conditions
  reg [CHANNELS-1:0] onReq;
  reg [CHANNELS-1:0] pinOff;
  integer k;
  always @* begin
    for (k = 0; k < CHANNELS; k = k + 1) begin
      if (!cfg_r[k][`CFG_CONTROLLED_ON])
        onReq[k] = 1'b1;
      else
        onReq[k] = (cfg_r[k][`CFG_USE_BUS] | cfg_r[k][`CFG_USE_PIN]) &
                   (!cfg_r[k][`CFG_USE_BUS] | runCmd_r[k]) &
                   (!cfg_r[k][`CFG_USE_PIN] | pinSync_r[k]);
      pinOff[k] = cfg_r[k][`CFG_CONTROLLED_ON] & cfg_r[k][`CFG_USE_PIN] & !pinSync_r[k];
    end
  end

  // Register writes and EEPROM control
  integer i;
  always @(posedge core_clk) begin
    if (sys_rst) begin
      page_r      <= 8'h00;
      lock_r      <= `LOCK_NONE;
      bcastMask_r <= 8'hFF;
      runCmd_r    <= {CHANNELS{1'b0}};
      cml_r       <= 1'b0;
      busy_r      <= 1'b0;
      initDone_r  <= 1'b0;
      bootLoad_r  <= 1'b1;
      eeStoreReq  <= 1'b0;
      eeLoadReq   <= 1'b0;
      cmdDone     <= 1'b0;
      cmdNack     <= 1'b0;
      cmdRdata    <= 16'h0000;
      // Pin-and-bus control out of reset
      for (i = 0; i < CHANNELS; i = i + 1)
        cfg_r[i] <= `CFG_RESET;
      for (i = 0; i < CHANNELS*10; i = i + 1)
        vreg_r[i] <= 16'h0000;
    end else begin
      cmdDone    <= take;
      cmdNack    <= take && nackNxt;
      cmdRdata   <= (take && !cmdWrite && !nackNxt) ? rdNxt : 16'h0000;
      eeStoreReq <= 1'b0;
      eeLoadReq  <= 1'b0;
      // Restore once after reset before anything may start
      if (bootLoad_r) begin
        bootLoad_r <= 1'b0;
        busy_r     <= 1'b1;
        eeLoadReq  <= 1'b1;
      end else if (busy_r && eeDone) begin
        busy_r     <= 1'b0;
        initDone_r <= 1'b1;
      end
      // Protocol errors set the unpaged error bit; a same-cycle clear loses to it
      if (take && nackNxt)
        cml_r <= 1'b1;
      else if (clrHit)
        cml_r <= 1'b0;
      if (doWr) begin
        case (cmdCode)
          `CMD_PAGE:       page_r      <= cmdWdata[7:0];
          `CMD_WRITE_LOCK: lock_r      <= cmdWdata[7:0];
          `CMD_BCAST_MASK: bcastMask_r <= cmdWdata[7:0];
          `CMD_STORE_ALL:  begin busy_r <= 1'b1; eeStoreReq <= 1'b1; end
          `CMD_RESTORE_ALL: begin busy_r <= 1'b1; eeLoadReq <= 1'b1; end
          `CMD_RUN, `CMD_SWITCH_CFG: begin
            // Broadcast reaches masked channels
            for (i = 0; i < CHANNELS; i = i + 1)
              if (pageBcast ? bcastMask_r[i] : (chan == i)) begin
                if (cmdCode == `CMD_RUN)
                  runCmd_r[i] <= cmdWdata[`RUN_ON_BIT];
                else
                  cfg_r[i] <= {cmdWdata[4:2], cmdWdata[0]};
              end
          end
          default: if (isVreg) vreg_r[vidx] <= cmdWdata;
        endcase
      end
    end
  end

  // Status, alert and channel sequencers
  integer c;
  always @(posedge core_clk) begin
    if (sys_rst) begin
      faultStat_r           <= {CHANNELS{1'b0}};
      latched_r             <= {CHANNELS{1'b0}};
      converterEnableOutput <= {CHANNELS{1'b0}};
      monitorSuspend        <= 1'b0;
      for (c = 0; c < CHANNELS; c = c + 1) begin
        chState_r[c] <= `CH_OFF;
        chCnt_r[c]   <= {CNT_W{1'b0}};
      end
    end else begin
      monitorSuspend <= busy_r;
      // Odd channels measuring current do not supervise voltage
      for (c = 0; c < CHANNELS; c = c + 1) begin
        // A fault set beats a clear
        if (faultSync_r[c] && !busy_r && !((c % 2 == 1) && oddCurrentMode[c/2]))
          faultStat_r[c] <= 1'b1;
        else if (clrHit && pageOk && chan == c)
          faultStat_r[c] <= 1'b0;
        // Latch releases only by commanding the channel off, never by a clear
        if (!onReq[c])
          latched_r[c] <= 1'b0;
        case (chState_r[c])
          `CH_OFF: begin
            // Start waits for restore and input
            if (onReq[c] && vinSync_r && initDone_r && !latched_r[c]) begin
              chState_r[c] <= `CH_DELAY_ON;
              chCnt_r[c]   <= TON_DELAY;
            end
          end
          `CH_DELAY_ON: begin
            // Dropped request abandons the start
            if (!onReq[c])
              chState_r[c] <= `CH_OFF;
            else if (chCnt_r[c] == {CNT_W{1'b0}}) begin
              chState_r[c]             <= `CH_ON;
              converterEnableOutput[c] <= 1'b1;
            end else
              chCnt_r[c] <= chCnt_r[c] - 1'b1;
          end
          `CH_ON: begin
            if (faultSync_r[c] && !busy_r && !((c % 2 == 1) && oddCurrentMode[c/2])) begin
              chState_r[c]             <= `CH_OFF;
              converterEnableOutput[c] <= 1'b0;
              latched_r[c]             <= 1'b1;
            end else if (!onReq[c]) begin
              if ((pinOff[c] && cfg_r[c][`CFG_FAST_OFF]) || !cfg_r[c][`CFG_CONTROLLED_ON] ||
                  !pinOff[c]) begin
                // Bus turn-off is immediate; pin turn-off only when fast-off is set
                if (pinOff[c] && !cfg_r[c][`CFG_FAST_OFF]) begin
                  chState_r[c] <= `CH_DELAY_OFF;
                  chCnt_r[c]   <= TOFF_DELAY;
                end else begin
                  chState_r[c]             <= `CH_OFF;
                  converterEnableOutput[c] <= 1'b0;
                end
              end else begin
                chState_r[c] <= `CH_DELAY_OFF;
                chCnt_r[c]   <= TOFF_DELAY;
              end
            end
          end
          `CH_DELAY_OFF: begin
            if (chCnt_r[c] == {CNT_W{1'b0}} || (pinOff[c] && cfg_r[c][`CFG_FAST_OFF])) begin
              chState_r[c]             <= `CH_OFF;
              converterEnableOutput[c] <= 1'b0;
            end else
              chCnt_r[c] <= chCnt_r[c] - 1'b1;
          end
          default: chState_r[c] <= `CH_OFF;
        endcase
      end
    end
  end

  // Alert pull tracks any set status bit
  reg [CHANNELS-1:0] alertSrc;
  always @* begin
    alertSrc = faultStat_r;
  end
  wire alertNow = (|alertSrc) | cml_r;
  assign hostAlertLineNOut = 1'b0;

  // Pull trails the status flops by one cycle
  always @(posedge core_clk) begin
    if (sys_rst)
      hostAlertLineNOe <= 1'b0;
    else
      hostAlertLineNOe <= alertNow;
  end

endmodule // pmbus_onoff_protect

// File: pmbus_onoff_defines.vh
`ifndef PMBUS_ONOFF_DEFINES_VH
`define PMBUS_ONOFF_DEFINES_VH

// Command codes
`define CMD_PAGE           8'h00
`define CMD_RUN            8'h01
`define CMD_SWITCH_CFG     8'h02
`define CMD_CLEAR_FAULTS   8'h03
`define CMD_WRITE_LOCK     8'h10
`define CMD_STORE_ALL      8'h15
`define CMD_RESTORE_ALL    8'h16
`define CMD_FEATURES       8'h19
`define CMD_VOUT_FORMAT    8'h20
`define CMD_VOUT_SETPOINT  8'h21
`define CMD_VOUT_CEILING   8'h24
`define CMD_MARGIN_UPPER   8'h25
`define CMD_MARGIN_LOWER   8'h26
`define CMD_OV_FAULT       8'h40
`define CMD_OV_WARN        8'h42
`define CMD_UV_WARN        8'h43
`define CMD_UV_FAULT       8'h44
`define CMD_GOOD_ASSERT    8'h5E
`define CMD_GOOD_DEASSERT  8'h5F
`define CMD_STATUS_SUMMARY 8'h78
`define CMD_STATUS_OUTPUT  8'h7A
`define CMD_BCAST_MASK     8'hE4

// Page values
`define PAGE_BROADCAST     8'hFF
`define PAGE_LAST          8'h07

// Write-lock encodings
`define LOCK_NONE          8'h00
`define LOCK_LEVEL1        8'h80
`define LOCK_LEVEL2        8'h40

// Power switch configuration fields
`define CFG_CONTROLLED_ON  3
`define CFG_USE_BUS        2
`define CFG_USE_PIN        1
`define CFG_FAST_OFF       0
`define CFG_RESET          4'hE
`define CFG_RD_ONE_BIT     8'h02

// Run command field and read-only values
`define RUN_ON_BIT         7
`define FEATURES_VALUE     8'hE0
`define VOUT_FORMAT_VALUE  8'h13
`define STATUS_CML_BIT     1
`define STATUS_VOUT_BIT    7

// Limit register indices within a page
`define VSEL_SETPOINT      4'h0
`define VSEL_CEILING       4'h1
`define VSEL_MARGIN_UP     4'h2
`define VSEL_MARGIN_LO     4'h3
`define VSEL_OV_FAULT      4'h4
`define VSEL_OV_WARN       4'h5
`define VSEL_UV_WARN       4'h6
`define VSEL_UV_FAULT      4'h7
`define VSEL_GOOD_ON       4'h8
`define VSEL_GOOD_OFF      4'h9
`define VREGS_PER_PAGE     7'h0A

// Channel states
`define CH_OFF             2'h0
`define CH_DELAY_ON        2'h1
`define CH_ON              2'h2
`define CH_DELAY_OFF       2'h3

`endif

// File: pmbus_onoff_protect_asserts.sv
`timescale 1ns/1ps
`include "pmbus_onoff_defines.vh"

module pmbus_onoff_protect_asserts (
  // Clock and reset
  input wire        core_clk,
  input wire        sys_rst,
  // Command port
  input wire        cmdValid,
  input wire        cmdWrite,
  input wire [7:0]  cmdCode,
  input wire        cmdDone,
  input wire        cmdNack,
  input wire [15:0] cmdRdata,
  // Alert and transfer engine
  input wire        hostAlertLineNOut,
  input wire        hostAlertLineNOe,
  input wire        eeStoreReq,
  input wire        eeLoadReq,
  input wire        eeDone,
  input wire        monitorSuspend
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence s_read(logic [7:0] code);
    cmdValid && !cmdWrite && cmdCode == code;
  endsequence

  sequence s_write(logic [7:0] code);
    cmdValid && cmdWrite && cmdCode == code;
  endsequence

  sequence s_transfer_start;
    eeStoreReq || eeLoadReq;
  endsequence

  a_done_follows_cmd: assert property (cmdValid |=> cmdDone)
    else $error("Command not answered next cycle");
  a_no_stray_done: assert property (!cmdValid |=> !cmdDone)
    else $error("Done without a command");
  a_nack_with_done: assert property (cmdNack |-> cmdDone)
    else $error("Refusal without done");
  a_rdata_quiet: assert property ((!cmdDone || cmdNack) |-> cmdRdata == 16'h0000)
    else $error("Read data not zero outside an accepted read");
  a_feature_read: assert property (s_read(`CMD_FEATURES) |=> !cmdNack && cmdRdata == 16'h00E0)
    else $error("Feature byte wrong");
  a_format_read: assert property (s_read(`CMD_VOUT_FORMAT) |=> !cmdNack && cmdRdata == 16'h0013)
    else $error("Voltage format byte wrong");
  a_store_cause: assert property (eeStoreReq |-> $past(cmdValid) && $past(cmdWrite) &&
    $past(cmdCode) == `CMD_STORE_ALL)
    else $error("Store started without a command");
  a_power_on_load: assert property ($fell(sys_rst) |-> ##[0:2] eeLoadReq)
    else $error("No restore after reset");
  a_suspend_follows: assert property (s_transfer_start |=> monitorSuspend)
    else $error("Monitoring not suspended during transfer");
  a_busy_write_nack: assert property (monitorSuspend && !$past(eeDone) ##0 s_write(cmdCode) |=> cmdNack)
    else $error("Write accepted during transfer");
  a_alert_open_drain: assert property (hostAlertLineNOut == 1'b0)
    else $error("Alert line data not low");
  a_nack_pulls_alert: assert property (cmdNack |=> hostAlertLineNOe)
    else $error("Refusal did not pull the alert line");
endmodule // pmbus_onoff_protect_asserts

bind pmbus_onoff_protect pmbus_onoff_protect_asserts pmbus_onoff_protect_asserts_inst (
  .core_clk(core_clk), .sys_rst(sys_rst), .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode),
  .cmdDone(cmdDone), .cmdNack(cmdNack), .cmdRdata(cmdRdata), .hostAlertLineNOut(hostAlertLineNOut),
  .hostAlertLineNOe(hostAlertLineNOe),
  .eeStoreReq(eeStoreReq), .eeLoadReq(eeLoadReq), .eeDone(eeDone), .monitorSuspend(monitorSuspend));

// File: ee_engine_model.sv
`timescale 1ns/1ps

module ee_engine_model (
  // Clock and reset
  input  wire core_clk,
  input  wire sys_rst,
  // Transfer requests and completion
  input  wire eeStoreReq,
  input  wire eeLoadReq,
  input  int  latency,
  output reg  eeDone
);
  int count;

  // Done is a single pulse, so a design that needs a held level is caught
  always @(posedge core_clk) begin
    eeDone <= 1'b0;
    if (sys_rst) begin
      count <= 0;
    end else if (eeStoreReq || eeLoadReq) begin
      count <= latency;
    end else if (count == 1) begin
      count <= 0;
      eeDone <= 1'b1;
    end else if (count > 1) begin
      count <= count - 1;
    end
  end
endmodule // ee_engine_model

// File: pmbus_onoff_protect_cmds_test.sv
`timescale 1ns/1ps
`include "pmbus_onoff_defines.vh"
`define CHECK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; $display("MISMATCH %0t: got %h exp %h", $time, g, e); end end

module pmbus_onoff_protect_cmds_test;
  reg         core_clk = 1'b0;
  reg         sys_rst = 1'b1;
  reg         cmdValid = 1'b0;
  reg         cmdWrite = 1'b0;
  reg  [7:0]  cmdCode = 8'h00;
  reg  [15:0] cmdWdata = 16'h0000;
  reg  [7:0]  runRequestPin = 8'h00;
  reg         inputSenseAboveOn = 1'b0;
  reg  [7:0]  channelFault = 8'h00;
  reg  [3:0]  oddCurrentMode = 4'h0;
  wire        cmdDone, cmdNack, alertOut, alertOe, eeStoreReq, eeLoadReq, eeDone, monitorSuspend;
  wire [15:0] cmdRdata;
  wire [7:0]  converterEnableOutput;
  wire        alertLineN;
  reg         lastNack;
  reg  [15:0] lastRdata;
  int         eeLat = 10;
  int         n;
  int         n_fail = 0;
  int         n_compared = 0;

  // Pull-up on the shared alert line
  assign alertLineN = alertOe ? alertOut : 1'b1;
  always #10 core_clk = ~core_clk;

  pmbus_onoff_protect #(.TON_DELAY(16'h0002), .TOFF_DELAY(16'h0002)) pmbus_onoff_protect_inst (
    .core_clk(core_clk), .sys_rst(sys_rst), .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode),
    .cmdWdata(cmdWdata), .cmdDone(cmdDone), .cmdNack(cmdNack), .cmdRdata(cmdRdata), .runRequestPin(runRequestPin),
    .inputSenseAboveOn(inputSenseAboveOn), .channelFault(channelFault), .oddCurrentMode(oddCurrentMode),
    .converterEnableOutput(converterEnableOutput), .hostAlertLineNOut(alertOut), .hostAlertLineNOe(alertOe),
    .eeStoreReq(eeStoreReq), .eeLoadReq(eeLoadReq), .eeDone(eeDone), .monitorSuspend(monitorSuspend));
  ee_engine_model ee_engine_model_inst (.core_clk(core_clk), .sys_rst(sys_rst), .eeStoreReq(eeStoreReq),
    .eeLoadReq(eeLoadReq), .latency(eeLat), .eeDone(eeDone));

  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask

  task automatic cmd(input logic wr, input logic [7:0] code, input logic [15:0] data);
    cmdValid = 1'b1;
    cmdWrite = wr;
    cmdCode = code;
    cmdWdata = data;
    cyc(1);
    lastNack = cmdNack;
    lastRdata = cmdRdata;
    cmdValid = 1'b0;
    cyc(1);
  endtask

  task automatic waitEn(input int ch, input logic v);
    for (n = 0; converterEnableOutput[ch] !== v && n < 40; n++) cyc(1);
  endtask

  // Suspend rises a cycle after the request, so look only after that
  task automatic waitIdle();
    cyc(2);
    for (n = 0; monitorSuspend !== 1'b0 && n < 100; n++) cyc(1);
    cyc(1);
  endtask

  task automatic test_restore();
    cyc(1);
    cmd(1'b1, `CMD_PAGE, 16'h0000);
    `CHECK(lastNack, 1'b1)
    cmd(1'b0, `CMD_FEATURES, 16'h0000);
    `CHECK(lastRdata, 16'h00E0)
    waitIdle();
    cmd(1'b0, `CMD_VOUT_FORMAT, 16'h0000);
    `CHECK(lastRdata, 16'h0013)
    cmd(1'b0, `CMD_SWITCH_CFG, 16'h0000);
    `CHECK(lastRdata, 16'h001E)
    cmd(1'b1, `CMD_SWITCH_CFG, 16'h00E5);
    cmd(1'b0, `CMD_SWITCH_CFG, 16'h0000);
    `CHECK(lastRdata, 16'h0007)
    cyc(20);
    `CHECK(converterEnableOutput[0], 1'b0)
    inputSenseAboveOn = 1'b1;
    waitEn(0, 1'b1);
    `CHECK(converterEnableOutput[0], 1'b1)
    $display("test_restore finished");
  endtask

  task automatic test_modes();
    logic e;
    cmd(1'b1, `CMD_PAGE, 16'h0001);
    for (int m = 0; m < 16; m++) begin
      cmd(1'b1, `CMD_SWITCH_CFG, 16'(16'h0010 | (m & 12)));
      cmd(1'b1, `CMD_RUN, m[1] ? 16'h0080 : 16'h0000);
      runRequestPin[1] = m[0];
      e = (m[3] | m[2]) & (!m[3] | m[1]) & (!m[2] | m[0]);
      cyc(20);
      `CHECK(converterEnableOutput[1], e)
      runRequestPin[1] = 1'b0;
      cmd(1'b1, `CMD_RUN, 16'h0000);
      cyc(12);
    end
    $display("test_modes finished");
  endtask

  task automatic test_fastoff();
    cmd(1'b1, `CMD_PAGE, 16'h0002);
    for (int f = 0; f < 2; f++) begin
      cmd(1'b1, `CMD_SWITCH_CFG, 16'(16'h0014 | f));
      runRequestPin[2] = 1'b1;
      waitEn(2, 1'b1);
      runRequestPin[2] = 1'b0;
      waitEn(2, 1'b0);
      `CHECK(f ? (n <= 4) : (n >= 5 && n <= 9), 1'b1)
      cyc(12);
    end
    $display("test_fastoff finished");
  endtask

  task automatic test_lock();
    logic [7:0] codes [10] = '{`CMD_VOUT_SETPOINT, `CMD_VOUT_CEILING, `CMD_MARGIN_UPPER, `CMD_MARGIN_LOWER,
      `CMD_OV_FAULT, `CMD_OV_WARN, `CMD_UV_WARN, `CMD_UV_FAULT, `CMD_GOOD_ASSERT, `CMD_GOOD_DEASSERT};
    cmd(1'b1, `CMD_WRITE_LOCK, 16'h0080);
    cmd(1'b1, `CMD_VOUT_SETPOINT, 16'h1234);
    `CHECK(lastNack, 1'b1)
    cmd(1'b1, `CMD_RUN, 16'h0000);
    `CHECK(lastNack, 1'b1)
    cmd(1'b1, `CMD_PAGE, 16'h0000);
    `CHECK(lastNack, 1'b0)
    cmd(1'b0, `CMD_VOUT_SETPOINT, 16'h0000);
    `CHECK(lastNack, 1'b0)
    cmd(1'b1, `CMD_WRITE_LOCK, 16'h0040);
    cmd(1'b1, `CMD_RUN, 16'h0000);
    `CHECK(lastNack, 1'b0)
    cmd(1'b1, `CMD_CLEAR_FAULTS, 16'h0000);
    `CHECK(lastNack, 1'b0)
    cmd(1'b1, `CMD_SWITCH_CFG, 16'h0000);
    `CHECK(lastNack, 1'b1)
    cmd(1'b1, `CMD_WRITE_LOCK, 16'h0023);
    `CHECK(lastNack, 1'b1)
    cmd(1'b1, `CMD_WRITE_LOCK, 16'h0000);
    for (int i = 0; i < 10; i++) cmd(1'b1, codes[i], 16'(16'hA500 + i));
    for (int i = 0; i < 10; i++) begin
      cmd(1'b0, codes[i], 16'h0000);
      `CHECK(lastRdata, 16'(16'hA500 + i))
    end
    oddCurrentMode = 4'h1;
    cmd(1'b1, `CMD_PAGE, 16'h0001);
    cmd(1'b1, `CMD_OV_FAULT, 16'h1111);
    `CHECK(lastNack, 1'b1)
    cmd(1'b1, `CMD_VOUT_SETPOINT, 16'h1111);
    `CHECK(lastNack, 1'b0)
    oddCurrentMode = 4'h0;
    $display("test_lock finished");
  endtask

  task automatic test_fault();
    cmd(1'b1, `CMD_PAGE, 16'h0003);
    cmd(1'b1, `CMD_CLEAR_FAULTS, 16'h0000);
    cyc(2);
    `CHECK(alertLineN, 1'b1)
    cmd(1'b0, `CMD_STATUS_SUMMARY, 16'h0000);
    `CHECK(lastRdata[1], 1'b0)
    cmd(1'b1, `CMD_SWITCH_CFG, 16'h0000);
    waitEn(3, 1'b1);
    channelFault[3] = 1'b1;
    waitEn(3, 1'b0);
    cyc(2);
    `CHECK(alertLineN, 1'b0)
    cmd(1'b1, `CMD_CLEAR_FAULTS, 16'h0000);
    cyc(3);
    `CHECK(alertLineN, 1'b0)
    cmd(1'b0, `CMD_STATUS_OUTPUT, 16'h0000);
    `CHECK(lastRdata[7], 1'b1)
    channelFault[3] = 1'b0;
    cyc(3);
    cmd(1'b1, `CMD_PAGE, 16'h0000);
    cmd(1'b1, `CMD_CLEAR_FAULTS, 16'h0000);
    cmd(1'b1, `CMD_PAGE, 16'h0003);
    cmd(1'b0, `CMD_STATUS_OUTPUT, 16'h0000);
    `CHECK(lastRdata[7], 1'b1)
    cmd(1'b1, `CMD_CLEAR_FAULTS, 16'h0000);
    cyc(20);
    `CHECK(alertLineN, 1'b1)
    `CHECK(converterEnableOutput[3], 1'b0)
    cmd(1'b0, `CMD_STATUS_OUTPUT, 16'h0000);
    `CHECK(lastRdata[7], 1'b0)
    cmd(1'b1, `CMD_PAGE, 16'h00FF);
    cmd(1'b1, `CMD_CLEAR_FAULTS, 16'h0000);
    `CHECK(lastNack, 1'b1)
    cmd(1'b1, `CMD_SWITCH_CFG, 16'h0010);
    `CHECK(lastNack, 1'b0)
    cmd(1'b1, `CMD_RUN, 16'h0080);
    `CHECK(lastNack, 1'b0)
    for (int p = 0; p < 8; p++) begin
      cmd(1'b1, `CMD_PAGE, 16'(p));
      cmd(1'b0, `CMD_SWITCH_CFG, 16'h0000);
      `CHECK(lastRdata, 16'h0012)
    end
    cyc(10);
    `CHECK(converterEnableOutput, 8'h00)
    $display("test_fault finished");
  endtask

  task automatic test_store();
    eeLat = 30;
    cmd(1'b1, `CMD_STORE_ALL, 16'h0000);
    `CHECK(lastNack, 1'b0)
    cyc(2);
    `CHECK(monitorSuspend, 1'b1)
    cmd(1'b1, `CMD_PAGE, 16'h0000);
    `CHECK(lastNack, 1'b1)
    cmd(1'b0, `CMD_WRITE_LOCK, 16'h0000);
    `CHECK(lastNack, 1'b0)
    waitIdle();
    `CHECK(monitorSuspend, 1'b0)
    cmd(1'b1, `CMD_RESTORE_ALL, 16'h0000);
    cmd(1'b1, `CMD_PAGE, 16'h0000);
    `CHECK(lastNack, 1'b1)
    waitIdle();
    cmd(1'b1, `CMD_PAGE, 16'h0000);
    `CHECK(lastNack, 1'b0)
    $display("test_store finished");
  endtask

  task automatic complete_run();
    $display("Compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (10000) @(posedge core_clk);
    n_fail++;
    $display("MISMATCH %0t: watchdog expired", $time);
    complete_run();
  end

  initial begin
    repeat (8) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    test_restore();
    test_modes();
    test_fastoff();
    test_lock();
    test_fault();
    test_store();
    complete_run();
  end
endmodule // pmbus_onoff_protect_cmds_test
